// file: rtl/lmts_task_checks.sv
// Wide-mode task state checks: fault gating and segment field fetches.
//
// Operation
// - Wide mode: jump, call, interrupts aimed at task segment or gate fault.
// - Wide mode: interrupt return with nested task flag 1 faults.
// - Wide mode: no hardware task switch; one wide task segment still read for fields.
// - Privilege stack pointers 0-2 fetched as halves, lows at 4, 12, 20.
// - Seven interrupt stack pointers, lows from 36 every 8 to 84.
// - I/O map base is a 16-bit byte offset added to segment base.
// - One segment from the task register serves wide and compatibility code.
`timescale 1ns/10ps
`default_nettype none
module lmts_task_checks
  import lmts_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               wide_mode,
  input  wire logic               compat_mode,
  input  wire lmts_xfer_req_type  xfer_req,
  input  wire logic               load_task_register_op,
  input  wire logic [63:0]        load_base,
  input  wire lmts_stack_req_type stack_req,
  input  wire logic               mem_ack,
  input  wire logic [31:0]        mem_rdata,
  output logic                    general_protection_fault,
  output logic                    task_switch_go,
  output lmts_mem_req_type        mem_req,
  output logic                    fetch_done,
  output logic [63:0]             fetch_value,
  output logic                    io_map_valid,
  output logic [63:0]             io_map_address,
  output logic                    busy
);

  //////////////////////////////////////////////////////////////////////////
  logic reset_meta;
  logic reset_sync_n;

  // The release is delayed two edges; assertion still acts at once.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_meta   <= 1'b0;
      reset_sync_n <= 1'b0;
    end else begin
      reset_meta   <= 1'b1;
      reset_sync_n <= reset_meta;
    end
  end

  function automatic logic [6:0] low_offset(input logic       use_ist,
                                            input logic [1:0] priv,
                                            input logic [2:0] ist);
    logic [6:0] off;
    off = LMTS_PRIV_SP_LOW_BASE + 7'(priv) * LMTS_PRIV_SP_STRIDE;
    if (use_ist) begin
      off = LMTS_IST_LOW_BASE + 7'(ist - 3'h1) * LMTS_IST_STRIDE;
    end
    return off;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  logic        fault;
  logic        next_fault;
  logic        go;
  logic        next_go;
  logic        is_task_xfer;

  always_comb begin
    is_task_xfer = xfer_req.target_task &&
                   (xfer_req.kind == LMTS_XFER_JMP   ||
                    xfer_req.kind == LMTS_XFER_CALL  ||
                    xfer_req.kind == LMTS_XFER_SWINT ||
                    xfer_req.kind == LMTS_XFER_HWINT);
    next_fault = 1'b0;
    next_go    = 1'b0;
    if (xfer_req.valid && wide_mode) begin
      if (is_task_xfer) begin
        next_fault = 1'b1;
      end else if (xfer_req.kind == LMTS_XFER_INTERRUPT_RETURN &&
                   xfer_req.nested_task_flag) begin
        next_fault = 1'b1;
      end
    end else if (xfer_req.valid) begin
      // Outside wide mode a task target or linked return may proceed.
      next_go = is_task_xfer || (xfer_req.kind == LMTS_XFER_INTERRUPT_RETURN &&
                                 xfer_req.nested_task_flag);
    end
  end

  always_ff @(posedge clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      fault <= 1'b0;
      go    <= 1'b0;
    end else begin
      fault <= next_fault;
      go    <= next_go;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  lmts_state_type state;
  lmts_state_type next_state;
  logic [63:0]    seg_base;
  logic [63:0]    next_seg_base;
  logic [6:0]     offset;
  logic [6:0]     next_offset;
  logic           io_req;
  logic           next_io_req;
  logic [31:0]    low_half;
  logic [31:0]    next_low_half;
  logic [63:0]    value;
  logic [63:0]    next_value;
  logic           done;
  logic           next_done;
  logic           io_valid;
  logic           next_io_valid;
  logic [63:0]    io_addr;
  logic [63:0]    next_io_addr;
  logic           ist_ok;
  logic           active;
  logic           next_active;
  lmts_mem_req_type next_mem_req;

  always_comb begin
    next_state    = state;
    next_seg_base = seg_base;
    next_offset   = offset;
    next_io_req   = io_req;
    next_low_half = low_half;
    next_value    = value;
    next_done     = 1'b0;
    next_io_valid = io_valid;
    next_io_addr  = io_addr;
    ist_ok = !stack_req.use_ist || stack_req.ist_index != LMTS_IST_NONE;
    if (load_task_register_op) begin
      // One segment serves both wide and compatibility code.
      next_seg_base = load_base;
      next_io_valid = 1'b0;
    end
    case (state)
      LMTS_IDLE: begin
        if (stack_req.valid && (wide_mode || compat_mode) && ist_ok &&
            stack_req.dest_priv <= LMTS_PRIV_MAX) begin
          next_io_req = stack_req.want_io_map;
          next_offset = stack_req.want_io_map ? LMTS_IO_MAP_OFFSET :
                        low_offset(stack_req.use_ist, stack_req.dest_priv,
                                   stack_req.ist_index);
          next_state  = LMTS_RD_LOW;
        end
      end
      LMTS_RD_LOW: begin
        next_state = LMTS_WAIT_LOW;
      end
      LMTS_WAIT_LOW: begin
        if (mem_ack) begin
          next_low_half = mem_rdata;
          if (io_req) begin
            // The 16-bit field sits in the upper half of its word.
            next_io_addr  = seg_base + 64'(mem_rdata >>
                                          LMTS_IO_MAP_FIELD_SHIFT);
            next_io_valid = 1'b1;
            next_value    = 64'(mem_rdata >> LMTS_IO_MAP_FIELD_SHIFT);
            next_done     = 1'b1;
            next_state    = LMTS_IDLE;
          end else begin
            next_offset = offset + LMTS_HALF_STEP;
            next_state  = LMTS_RD_HIGH;
          end
        end
      end
      LMTS_RD_HIGH: begin
        next_state = LMTS_WAIT_HIGH;
      end
      LMTS_WAIT_HIGH: begin
        if (mem_ack) begin
          next_value = {mem_rdata, low_half};
          next_done  = 1'b1;
          next_state = LMTS_DONE;
        end
      end
      LMTS_DONE: begin
        next_state = LMTS_IDLE;
      end
      default: begin
        next_state = LMTS_IDLE;
      end
    endcase
    // Busy comes from the next state, so it leaves a flop yet matches state.
    next_active          = (next_state != LMTS_IDLE);
    // The read strobe is registered, so it lasts one cycle per half.
    next_mem_req.valid   = (next_state == LMTS_RD_LOW ||
                            next_state == LMTS_RD_HIGH);
    next_mem_req.address = next_seg_base + 64'(next_offset);
  end

  always_ff @(posedge clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      state    <= LMTS_IDLE;
      seg_base <= 64'h0;
      offset   <= 7'h0;
      io_req   <= 1'b0;
      low_half <= 32'h0;
      value    <= 64'h0;
      done     <= 1'b0;
      io_valid <= 1'b0;
      io_addr  <= 64'h0;
      active   <= 1'b0;
      mem_req  <= '0;
    end else begin
      state    <= next_state;
      seg_base <= next_seg_base;
      offset   <= next_offset;
      io_req   <= next_io_req;
      low_half <= next_low_half;
      value    <= next_value;
      done     <= next_done;
      io_valid <= next_io_valid;
      io_addr  <= next_io_addr;
      active   <= next_active;
      mem_req  <= next_mem_req;
    end
  end

  assign general_protection_fault = fault;
  assign task_switch_go           = go;
  assign fetch_done               = done;
  assign fetch_value              = value;
  assign io_map_valid             = io_valid;
  assign io_map_address           = io_addr;
  assign busy                     = active;

endmodule
`default_nettype wire

// file: rtl/lmts_pkg.sv
// Package for the wide-mode task state checks block.
package lmts_pkg;

  localparam logic [6:0]  LMTS_PRIV_SP_LOW_BASE   = 7'h04;
  localparam logic [6:0]  LMTS_PRIV_SP_STRIDE     = 7'h08;
  localparam logic [6:0]  LMTS_IST_LOW_BASE       = 7'h24;
  localparam logic [6:0]  LMTS_IST_STRIDE         = 7'h08;
  localparam logic [6:0]  LMTS_IST_LAST_LOW       = 7'h54;
  localparam logic [6:0]  LMTS_IO_MAP_OFFSET      = 7'h64;
  localparam logic [6:0]  LMTS_HALF_STEP          = 7'h04;
  localparam logic [15:0] LMTS_IO_MAP_FIELD_SHIFT = 16'h0010;
  localparam logic [1:0]  LMTS_PRIV_MAX           = 2'h2;
  localparam logic [2:0]  LMTS_IST_NONE           = 3'h0;

  typedef enum logic [2:0] {
    LMTS_XFER_JMP    = 3'h0,
    LMTS_XFER_CALL   = 3'h1,
    LMTS_XFER_SWINT  = 3'h2,
    LMTS_XFER_HWINT  = 3'h3,
    LMTS_XFER_INTERRUPT_RETURN   = 3'h4,
    LMTS_XFER_OTHER  = 3'h5
  } lmts_xfer_type;

  typedef enum logic [2:0] {
    LMTS_IDLE      = 3'b000,
    LMTS_RD_LOW    = 3'b001,
    LMTS_WAIT_LOW  = 3'b011,
    LMTS_RD_HIGH   = 3'b010,
    LMTS_WAIT_HIGH = 3'b110,
    LMTS_DONE      = 3'b100
  } lmts_state_type;

  typedef struct packed {
    logic          valid;
    lmts_xfer_type kind;
    logic          target_task;
    logic          nested_task_flag;
  } lmts_xfer_req_type;

  typedef struct packed {
    logic       valid;
    logic       use_ist;
    logic [1:0] dest_priv;
    logic [2:0] ist_index;
    logic       want_io_map;
  } lmts_stack_req_type;

  typedef struct packed {
    logic        valid;
    logic [63:0] address;
  } lmts_mem_req_type;

endpackage

// file: testbench/lmts_task_checks_assertions.sv
// Checker for the wide-mode task state checks block.
`timescale 1ns/10ps
`default_nettype none
module lmts_task_checks_chk
  import lmts_pkg::*;
(
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic               wide_mode,
  input wire lmts_xfer_req_type  xfer_req,
  input wire logic               load_task_register_op,
  input wire logic [63:0]        load_base,
  input wire lmts_stack_req_type stack_req,
  input wire logic               mem_ack,
  input wire logic [31:0]        mem_rdata,
  input wire logic               general_protection_fault,
  input wire logic               task_switch_go,
  input wire lmts_mem_req_type   mem_req,
  input wire logic               fetch_done,
  input wire logic [63:0]        fetch_value,
  input wire logic               io_map_valid,
  input wire logic [63:0]        io_map_address,
  input wire logic               busy
);
  logic [63:0] base;
  logic [63:0] prev;
  logic [31:0] word;
  logic        take;
  // Shadow copies let address checks avoid deep or variable $past depths.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base <= '0;
      prev <= '0;
      word <= '0;
    end else begin
      if (load_task_register_op) base <= load_base;
      if (mem_req.valid) prev <= mem_req.address;
      if (mem_ack) word <= mem_rdata;
    end
  end
  assign take = stack_req.valid && !busy && wide_mode &&
                stack_req.dest_priv <= 2'h2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  a_task_fault: assert property (
    xfer_req.valid && wide_mode && xfer_req.target_task &&
    xfer_req.kind <= LMTS_XFER_HWINT |=> general_protection_fault)
    else $error("no fault on task transfer");
  a_interrupt_return_fault: assert property (
    xfer_req.valid && wide_mode && xfer_req.kind == LMTS_XFER_INTERRUPT_RETURN &&
    xfer_req.nested_task_flag |=> general_protection_fault)
    else $error("no fault on nested return");
  a_fault_cause: assert property (
    general_protection_fault |-> $past(xfer_req.valid) && $past(wide_mode))
    else $error("fault without cause");
  a_no_switch: assert property (
    task_switch_go |-> $past(xfer_req.valid) && !$past(wide_mode))
    else $error("task switch in wide mode");
  a_priv_half: assert property (
    take && !stack_req.use_ist && !stack_req.want_io_map |=> mem_req.valid
    && mem_req.address == base + {59'h0, $past(stack_req.dest_priv), 3'h4})
    else $error("wrong stack pointer address");
  a_ist_half: assert property (
    take && stack_req.use_ist && stack_req.ist_index != 3'h0 &&
    !stack_req.want_io_map |=>
    mem_req.address == base + {58'h0, $past(stack_req.ist_index), 3'h0}
    + 64'h1C) else $error("wrong interrupt stack address");
  a_high_half: assert property (
    mem_req.valid && $past(mem_ack) |-> mem_req.address == prev + 64'h4)
    else $error("upper half not at offset plus four");
  a_done_value: assert property (
    fetch_done && !$rose(io_map_valid) |-> $past(mem_ack) &&
    fetch_value[63:32] == word) else $error("fetched value wrong");
  a_io_address: assert property (
    $rose(io_map_valid) |-> io_map_address == base + {48'h0, word[31:16]})
    else $error("io map address wrong");
endmodule
bind lmts_task_checks lmts_task_checks_chk u_chk (
  .clk(clk), .reset_n(reset_n), .wide_mode(wide_mode), .xfer_req(xfer_req),
  .load_task_register_op(load_task_register_op), .load_base(load_base),
  .stack_req(stack_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
  .general_protection_fault(general_protection_fault), .busy(busy),
  .task_switch_go(task_switch_go), .mem_req(mem_req),
  .fetch_done(fetch_done), .fetch_value(fetch_value),
  .io_map_valid(io_map_valid), .io_map_address(io_map_address));
`default_nettype wire

// file: testbench/tb_long_mode_task_state_checks.sv
// Testbench for the wide-mode task state checks block.
`timescale 1ns/10ps
`default_nettype none
module tb_long_mode_task_state_checks;
  import lmts_pkg::*;
  logic clk = 0, reset_n = 0, wide_mode = 0, compat_mode = 0, ld_op = 0;
  logic mem_ack = 0, fault, go, done, io_v, busy;
  logic [63:0] load_base = '0, base = '0, rd_addr, value, io_addr;
  logic [31:0] mem_rdata = '0;
  lmts_xfer_req_type  xfer_req = '0;
  lmts_stack_req_type stack_req = '0;
  lmts_mem_req_type   mem_req;
  int err_total = 0, cmp_count = 0, cyc = 0;
  lmts_task_checks dut (.clk(clk), .reset_n(reset_n), .wide_mode(wide_mode),
    .compat_mode(compat_mode), .xfer_req(xfer_req), .load_base(load_base),
    .load_task_register_op(ld_op), .stack_req(stack_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .general_protection_fault(fault),
    .task_switch_go(go), .mem_req(mem_req), .fetch_done(done),
    .fetch_value(value), .io_map_valid(io_v), .io_map_address(io_addr),
    .busy(busy));
  initial forever #4 clk = ~clk;
  // The run needs well under a thousand cycles; the ceiling leaves margin.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] mem_word(input logic [63:0] off);
    return {16'hBEEF, off[15:0]};
  endfunction
  task automatic chk(input logic [63:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ld(input logic [63:0] b);
    @(negedge clk);
    load_base = b;
    ld_op = 1;
    @(negedge clk);
    ld_op = 0;
    base = b;
  endtask
  task automatic xfer(input logic w, input lmts_xfer_type k,
                      input logic tt, nt, ef, eg);
    @(negedge clk);
    wide_mode = w;
    xfer_req = '{1'b1, k, tt, nt};
    @(negedge clk);
    xfer_req = '0;
    chk(fault, ef);
    chk(go, eg);
  endtask
  // The answer may be delayed by dly cycles to act as a slow memory.
  task automatic fetch(input logic ui, input logic [1:0] p,
                       input logic [2:0] n, input logic io, input int nr, dly);
    int cnt = 0;
    int dn = 0;
    @(negedge clk);
    stack_req = '{1'b1, ui, p, n, io};
    @(negedge clk);
    stack_req = '0;
    chk(64'(busy), 64'(nr != 0));
    repeat (40) begin
      if (done) dn++;
      if (mem_req.valid) begin
        rd_addr = mem_req.address;
        cnt++;
        // The strobe cycle itself is too early for an answer.
        repeat (dly + 1) @(negedge clk);
        mem_ack = 1;
        mem_rdata = mem_word(rd_addr - base);
        @(negedge clk);
        mem_ack = 0;
      end else @(negedge clk);
    end
    chk(64'(cnt), 64'(nr));
    chk(64'(dn), 64'(nr != 0));
  endtask
  task automatic t_faults;
    for (int k = 0; k < 4; k++) xfer(1, lmts_xfer_type'(k), 1, 0, 1, 0);
    xfer(1, LMTS_XFER_OTHER, 1, 0, 0, 0);
    xfer(1, LMTS_XFER_JMP, 0, 0, 0, 0);
    xfer(1, LMTS_XFER_INTERRUPT_RETURN, 0, 1, 1, 0);
    xfer(1, LMTS_XFER_INTERRUPT_RETURN, 0, 0, 0, 0);
    xfer(0, LMTS_XFER_CALL, 1, 0, 0, 1);
    $display("test faults done");
  endtask
  task automatic t_fetch;
    logic [63:0] o;
    ld(64'h1000_0000);
    wide_mode = 1;
    for (int i = 0; i < 10; i++) begin
      o = 64'(i < 3 ? 4 + 8 * i : 12 + 8 * i);
      fetch(i > 2, 2'(i < 3 ? i : 0), 3'(i > 2 ? i - 2 : 0), 0, 2, i % 3);
      chk(value, {mem_word(o + 64'h4), mem_word(o)});
    end
    $display("test fetch done");
  endtask
  task automatic t_io;
    fetch(0, 2'h0, 3'h0, 1, 1, 1);
    chk(io_v, 1);
    chk(value, 64'hBEEF);
    chk(io_addr, 64'h1000_BEEF);
    ld(64'h2000_0000);
    chk(io_v, 0);
    wide_mode = 0;
    compat_mode = 1;
    fetch(0, 2'h2, 3'h0, 0, 2, 0);
    chk(value, {mem_word(64'h18), mem_word(64'h14)});
    $display("test io map done");
  endtask
  task automatic t_refuse;
    fetch(1, 2'h0, 3'h0, 0, 0, 0);
    fetch(0, 2'h3, 3'h0, 0, 0, 0);
    compat_mode = 0;
    fetch(0, 2'h0, 3'h0, 0, 0, 0);
    $display("test refusals done");
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1;
    repeat (5) @(negedge clk);
    t_faults();
    t_fetch();
    t_io();
    t_refuse();
    summarize();
  end
endmodule
`default_nettype wire
